// ---- pkg/iocd_pkg.sv ----
package iocd_pkg;

	// ------------------------------------------------------------
	// Register map, byte addresses on the APB side
	// ------------------------------------------------------------
	localparam logic [7:0] OFF_CMD   = 8'h00;
	localparam logic [7:0] OFF_EXT   = 8'h04;
	localparam logic [7:0] OFF_WR0   = 8'h08;
	localparam logic [7:0] OFF_STAT  = 8'h0C;
	localparam logic [7:0] OFF_BUF   = 8'h10;
	localparam logic [7:0] OFF_TGT   = 8'h14;
	localparam logic [7:0] OFF_CHR   = 8'h18;
	localparam logic [7:0] OFF_LOCAL = 8'h20;
	localparam int         LOCAL_N   = 8;

	// Status register fields
	localparam int STB_BUSY  = 0;
	localparam int STB_BADOP = 1;
	localparam int STB_NOP   = 2;
	localparam int STB_PERR  = 3;
	localparam int STB_TAKEN = 4;
	localparam int STB_FN    = 8;

	// Reset values
	localparam logic [7:0]  WR0_RST = 8'h00;
	localparam logic [7:0]  CHR_RST = 8'h00;
	localparam logic [15:0] INS_RST = 16'h0000;

	// ------------------------------------------------------------
	// Instruction encodings
	// ------------------------------------------------------------
	localparam logic [0:3] OP_IMM   = 4'hB;
	localparam logic [0:3] FN_IOLD  = 4'h0;
	localparam logic [0:3] FN_IOSN  = 4'h4;
	localparam logic [0:3] FN_SILS  = 4'h5;
	localparam logic [0:3] FN_PSNS  = 4'h6;
	localparam logic [0:3] FN_IOCL  = 4'h8;
	localparam logic [0:3] FN_PLD   = 4'hA;
	localparam logic [0:3] FN_IOCS  = 4'hC;
	localparam logic [0:3] FN_BOC   = 4'hD;
	localparam logic [0:3] DEV_CHAN = 4'h0;
	localparam logic [0:3] DEV_INIT = 4'hF;

	// ------------------------------------------------------------
	// Timing: attachment settle time before the inbound sample
	// ------------------------------------------------------------
	localparam int CLK_NS     = 8;
	localparam int SETTLE_NS  = 24;
	localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [1:0] SETTLE_LAST = 2'(SETTLE_CYC - 1);

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		S_IDLE, S_ADDR, S_WAIT, S_XFER, S_DONE
	} iocd_state_t;

	typedef struct packed {
		logic [0:3] op;
		logic [0:3] mod;
		logic [0:3] fn;
		logic       h;
		logic [0:2] rrr;
	} iocd_instr_t;

	typedef struct packed {
		logic [0:15] data;
		logic [1:0]  par;
		logic [1:0]  oe;
	} iocd_bus_t;

	typedef struct packed {
		logic       stb;
		logic [0:3] func;
		logic [0:6] modx;
		logic       dstb;
		logic       init;
	} iocd_cmd_t;

endpackage

// ---- rtl/iocd_decode.sv ----
// Local design decisions: the APB register port and the register offsets.
module iocd_decode
	import iocd_pkg::*;
(
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        nrst,
	// APB slave
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Bidirectional channel bus pins
	input  wire logic [0:15] bidir_channel_bus_in,
	input  wire logic [1:0]  bidir_channel_par_in,
	output iocd_bus_t        bidir_channel_bus_out,
	// Attachment control
	input  wire logic        branch_cond_in,
	output iocd_cmd_t        chan_cmd
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	iocd_state_t  st_q;
	logic [1:0]   cnt_q;
	logic         go_q;
	logic [0:15]  instr_q;
	logic [0:15]  ext_q;
	logic [0:7]   work_reg_zero_low_byte_q;
	logic [0:7]   buf_q;
	logic [0:7]   chan_reg_q;
	logic [0:11]  tgt_q;
	logic         badop_q;
	logic         nop_q;
	logic         perr_q;
	logic         taken_q;
	logic [0:15]  local_storage_register_q [LOCAL_N];
	logic [0:15]  bus_s1_q;
	logic [0:15]  bus_s2_q;
	logic [1:0]   par_s1_q;
	logic [1:0]   par_s2_q;
	logic         cond_s1_q;
	logic         cond_s2_q;

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	// Attachments run off our clock only loosely, so two stages
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			bus_s1_q  <= '0;
			bus_s2_q  <= '0;
			par_s1_q  <= '0;
			par_s2_q  <= '0;
			cond_s1_q <= 1'b0;
			cond_s2_q <= 1'b0;
		end else begin
			bus_s1_q  <= bidir_channel_bus_in;
			bus_s2_q  <= bus_s1_q;
			par_s1_q  <= bidir_channel_par_in;
			par_s2_q  <= par_s1_q;
			cond_s1_q <= branch_cond_in;
			cond_s2_q <= cond_s1_q;
		end
	end

	// ------------------------------------------------------------
	// Instruction decode
	// ------------------------------------------------------------
	iocd_instr_t ins;
	logic [0:3]  dev;
	logic        fn_def;
	logic        is_out;
	logic        is_in;
	logic        is_boc;
	logic        self_sel;
	logic        bad_op;
	logic [2:0]  idx;
	logic [0:7]  src_byte;
	logic [0:7]  addr_byte;

	assign ins      = instr_q;
	assign dev      = work_reg_zero_low_byte_q[0:3];
	assign is_boc   = (ins.fn == FN_BOC);
	// Branch needs the zero tail of the first halfword
	assign bad_op   = (ins.op != OP_IMM) ||
	                  (is_boc && {ins.h, ins.rrr} != 4'h0);
	assign self_sel = (dev == DEV_CHAN) && (ins.fn != FN_SILS);
	// Level-wide sense sends level address in place of device
	assign addr_byte = {dev, ins.mod};
	// Processor load reuses rrr, so data comes from register 0
	assign idx      = (ins.fn == FN_PLD) ? 3'd0 : ins.rrr;
	assign src_byte = ins.h ? local_storage_register_q[idx][0:7]
	                        : local_storage_register_q[idx][8:15];

	// Function classes
	always_comb begin
		fn_def = 1'b1;
		is_out = 1'b0;
		is_in  = 1'b0;
		case (ins.fn)
			FN_IOLD, FN_IOCL, FN_PLD:          is_out = 1'b1;
			FN_IOSN, FN_SILS, FN_PSNS, FN_IOCS: is_in  = 1'b1;
			FN_BOC:                            is_out = 1'b0;
			default:                           fn_def = 1'b0;
		endcase
	end

	// ------------------------------------------------------------
	// APB slave
	// ------------------------------------------------------------
	logic        acc;
	logic        wr_en;
	logic        busy;
	logic        mapped;
	logic        loc_hit;
	logic [2:0]  loc_idx;
	logic [31:0] rd_w;
	logic [31:0] stat_w;

	assign acc     = psel && penable;
	assign wr_en   = acc && pwrite && pready;
	assign busy    = (st_q != S_IDLE) || go_q;
	assign loc_hit = (paddr >= OFF_LOCAL) &&
	                 (paddr < 8'(OFF_LOCAL + 8'(4 * LOCAL_N)));
	assign loc_idx = 3'(paddr[4:2]);

	// Status word
	always_comb begin
		stat_w                  = '0;
		stat_w[STB_BUSY]        = busy;
		stat_w[STB_BADOP]       = badop_q;
		stat_w[STB_NOP]         = nop_q;
		stat_w[STB_PERR]        = perr_q;
		stat_w[STB_TAKEN]       = taken_q;
		stat_w[STB_FN +: 4]     = ins.fn;
	end

	// Read mux and decode of unmapped words
	always_comb begin
		mapped = 1'b1;
		rd_w   = '0;
		case (paddr)
			OFF_CMD:  rd_w = {16'h0000, instr_q};
			OFF_EXT:  rd_w = {16'h0000, ext_q};
			OFF_WR0:  rd_w = {24'h000000, work_reg_zero_low_byte_q};
			OFF_STAT: rd_w = stat_w;
			OFF_BUF:  rd_w = {24'h000000, buf_q};
			OFF_TGT:  rd_w = {20'h00000, tgt_q};
			OFF_CHR:  rd_w = {24'h000000, chan_reg_q};
			default: begin
				mapped = loc_hit && (paddr[1:0] == 2'b00);
				if (mapped)
					rd_w = {16'h0000, local_storage_register_q[loc_idx]};
			end
		endcase
	end

	// One wait state; a command written while busy is refused
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= '0;
		end else begin
			pready  <= acc && !pready;
			pslverr <= acc && !pready &&
			           (!mapped || (pwrite && paddr == OFF_CMD && busy));
			prdata  <= (acc && !pready && !pwrite) ? rd_w : '0;
		end
	end

	// Processor-written registers; a command write starts a decode
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			instr_q                  <= INS_RST;
			ext_q                    <= INS_RST;
			work_reg_zero_low_byte_q <= WR0_RST;
			go_q                     <= 1'b0;
		end else begin
			go_q <= 1'b0;
			if (wr_en && !pslverr) begin
				case (paddr)
					OFF_CMD: begin
						instr_q <= pwdata[15:0];
						go_q    <= 1'b1;
					end
					OFF_EXT: ext_q <= pwdata[15:0];
					OFF_WR0: work_reg_zero_low_byte_q <= pwdata[7:0];
					default: ;
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// Local storage registers
	// ------------------------------------------------------------
	// Software and a sense completion both write; sense wins
	for (genvar i = 0; i < LOCAL_N; i++) begin : g_local
		always_ff @(posedge sys_clk) begin
			if (!nrst) begin
				local_storage_register_q[i] <= '0;
			end else if (st_q == S_DONE && is_in && idx == 3'(i)) begin
				if (ins.h)
					local_storage_register_q[i][0:7]  <= buf_q;
				else
					local_storage_register_q[i][8:15] <= buf_q;
			end else if (wr_en && !pslverr && loc_hit &&
			             loc_idx == 3'(i)) begin
				local_storage_register_q[i] <= pwdata[15:0];
			end
		end
	end

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			st_q  <= S_IDLE;
			cnt_q <= '0;
		end else begin
			case (st_q)
				S_IDLE:
					if (go_q && !bad_op && fn_def)
						st_q <= S_ADDR;
				S_ADDR: begin
					cnt_q <= '0;
					st_q  <= S_WAIT;
				end
				S_WAIT: begin
					cnt_q <= cnt_q + 2'd1;
					if (cnt_q == SETTLE_LAST)
						st_q <= S_XFER;
				end
				S_XFER:  st_q <= S_DONE;
				S_DONE:  st_q <= S_IDLE;
				default: st_q <= S_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Channel buffer and channel register
	// ------------------------------------------------------------
	// All data bytes in either direction stage through buf_q; the address byte goes straight from addr_byte
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			buf_q      <= '0;
			chan_reg_q <= CHR_RST;
		end else if (st_q == S_ADDR && is_out) begin
			buf_q <= src_byte;
		end else if (st_q == S_XFER && is_in) begin
			buf_q <= self_sel ? chan_reg_q : bus_s2_q[0:7];
		end else if (st_q == S_XFER && is_out && self_sel) begin
			chan_reg_q <= buf_q;
		end
	end

	// ------------------------------------------------------------
	// Sticky status and branch outcome
	// ------------------------------------------------------------
	// Write one to clear; a new event in the same cycle wins
	logic clr_stat;
	logic perr_evt;
	assign clr_stat = wr_en && !pslverr && paddr == OFF_STAT;
	assign perr_evt = st_q == S_XFER && is_in && !self_sel &&
	                  !(^{bus_s2_q[0:7], par_s2_q[1]});

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			badop_q <= 1'b0;
			nop_q   <= 1'b0;
			perr_q  <= 1'b0;
		end else begin
			badop_q <= (go_q && bad_op) ||
			           (badop_q && !(clr_stat && pwdata[STB_BADOP]));
			nop_q   <= (go_q && !bad_op && !fn_def) ||
			           (nop_q && !(clr_stat && pwdata[STB_NOP]));
			perr_q  <= perr_evt ||
			           (perr_q && !(clr_stat && pwdata[STB_PERR]));
		end
	end

	// Target is latched from the second halfword at issue
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			taken_q <= 1'b0;
			tgt_q   <= '0;
		end else if (st_q == S_ADDR && is_boc) begin
			taken_q <= 1'b0;
			tgt_q   <= ext_q[4:15];
		end else if (st_q == S_XFER && is_boc) begin
			taken_q <= cond_s2_q;
		end
	end

	// ------------------------------------------------------------
	// Attachment outputs
	// ------------------------------------------------------------
	// Inbound lane is never driven; outbound carries odd parity
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			bidir_channel_bus_out <= '0;
			chan_cmd              <= '0;
		end else begin
			chan_cmd.stb  <= 1'b0;
			chan_cmd.dstb <= 1'b0;
			chan_cmd.init <= 1'b0;
			bidir_channel_bus_out.oe[0] <= 1'b0;
			if (st_q == S_IDLE && go_q && !bad_op && fn_def) begin
				bidir_channel_bus_out.data[8:15] <= addr_byte;
				bidir_channel_bus_out.par[1]     <= ~^addr_byte;
				bidir_channel_bus_out.oe[1]      <= !self_sel;
				chan_cmd.stb  <= !self_sel;
				chan_cmd.init <= !self_sel && dev == DEV_INIT;
				chan_cmd.func <= ins.fn;
				chan_cmd.modx <= (ins.fn == FN_PLD) ?
				                 {ins.rrr, ins.mod} :
				                 {3'b000, ins.mod};
			end else if (st_q == S_WAIT && cnt_q == SETTLE_LAST &&
			             is_out && !self_sel) begin
				bidir_channel_bus_out.data[8:15] <= buf_q;
				bidir_channel_bus_out.par[1]     <= ~^buf_q;
				chan_cmd.dstb <= 1'b1;
			end else if (st_q == S_XFER) begin
				bidir_channel_bus_out.oe[1] <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);

	property p_addr_byte;
		chan_cmd.stb |-> bidir_channel_bus_out.oe[1] &&
		  bidir_channel_bus_out.data[8:15] == addr_byte;
	endproperty
	a_addr_byte: assert property (p_addr_byte)
		else $error("address byte not on outbound lane");

	property p_self;
		chan_cmd.stb |-> bidir_channel_bus_out.data[8:11] != DEV_CHAN
		  || chan_cmd.func == FN_SILS;
	endproperty
	a_self: assert property (p_self)
		else $error("command strobed for channel address");

	property p_in_quiet;
		!bidir_channel_bus_out.oe[0];
	endproperty
	a_in_quiet: assert property (p_in_quiet)
		else $error("inbound lane driven");

	property p_parity;
		bidir_channel_bus_out.oe[1] |->
		  ^{bidir_channel_bus_out.data[8:15],
		    bidir_channel_bus_out.par[1]};
	endproperty
	a_parity: assert property (p_parity)
		else $error("outbound parity not odd");

	property p_nop;
		go_q && !bad_op && !fn_def |=> st_q == S_IDLE && nop_q
		  && !chan_cmd.stb;
	endproperty
	a_nop: assert property (p_nop)
		else $error("undefined function not ignored");

	property p_inbound;
		st_q == S_XFER && is_in && !self_sel |=>
		  buf_q == $past(bus_s2_q[0:7]);
	endproperty
	a_inbound: assert property (p_inbound)
		else $error("inbound byte missed the buffer");

	property p_branch;
		st_q == S_XFER && is_boc |=> taken_q == $past(cond_s2_q)
		  ##1 st_q == S_IDLE;
	endproperty
	a_branch: assert property (p_branch)
		else $error("branch outcome wrong");

	property p_dstb;
		chan_cmd.stb && is_out && !self_sel |-> ##4 chan_cmd.dstb
		  && bidir_channel_bus_out.data[8:15] == buf_q;
	endproperty
	a_dstb: assert property (p_dstb)
		else $error("outbound data strobe late or wrong");

	property p_badop;
		go_q && bad_op |=> badop_q && st_q == S_IDLE;
	endproperty
	a_badop: assert property (p_badop)
		else $error("foreign op code accepted");

endmodule

// ---- verif/iocd_attach_model.sv ----
module iocd_attach_model
	import iocd_pkg::*;
(
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        nrst,
	// Channel side of the bus
	input  iocd_bus_t        bus_o,
	input  iocd_cmd_t        cmd,
	output logic      [0:15] bus_i,
	output logic      [1:0]  par_i,
	output logic             cond,
	// Scenario controls
	input  wire logic [7:0]  id_bits,
	input  wire logic [7:0]  sense_val,
	input  wire logic        cond_val
);
	timeunit 1ns;
	timeprecision 1ps;

	// ------------------------------------------------------------
	// Attachment answer
	// ------------------------------------------------------------
	logic [7:0] drv_q;
	logic [3:0] hold_q;

	// Answer one command, then release; a released lane toggles so
	// a stale byte never passes for an answer
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			hold_q <= 4'h0;
			drv_q  <= 8'h00;
		end else if (cmd.stb) begin
			hold_q <= 4'h0;
			drv_q  <= ~drv_q;
			if (cmd.func inside {FN_IOSN, FN_PSNS, FN_IOCS} &&
			    bus_o.data[8:11] inside {4'h2, 4'h4, 4'h5, 4'h8, 4'h9,
			    4'hA, 4'hB, 4'hC, 4'hE}) begin
				hold_q <= 4'h8;
				drv_q  <= sense_val;
			end
			// Level zero never answers
			if (cmd.func == FN_SILS && bus_o.data[8:11] == 4'h2) begin
				hold_q <= 4'h8;
				drv_q  <= id_bits & 8'h80;
			end
			if (cmd.func == FN_SILS && bus_o.data[8:11] == 4'h4) begin
				hold_q <= 4'h8;
				drv_q  <= id_bits & 8'hF2;
			end
		end else if (hold_q != 4'h0) begin
			hold_q <= hold_q - 4'h1;
		end else begin
			drv_q <= ~drv_q;
		end
	end

	// Wire levels: inbound lane ours, outbound lane the channel's
	assign bus_i[0:7]  = drv_q;
	assign bus_i[8:15] = bus_o.oe[1] ? bus_o.data[8:15] : ~drv_q;
	assign par_i[1]    = ~^drv_q;
	assign par_i[0]    = bus_o.oe[1] ? ~^bus_o.data[8:15] : drv_q[0];
	assign cond        = cond_val;
endmodule

// ---- verif/test_io_channel_instruction_decode.sv ----
module test_io_channel_instruction_decode
	import iocd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// ------------------------------------------------------------
	// Signals and instances
	// ------------------------------------------------------------
	logic        sys_clk = 1'b0;
	logic        nrst = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [0:15] bus_i;
	logic [1:0]  par_i;
	logic        cond;
	iocd_bus_t   bus_o;
	iocd_cmd_t   cmd;
	logic [7:0]  id_bits = 8'h00;
	logic [7:0]  sense_val = 8'h00;
	logic        cond_val = 1'b0;
	int          bad_count = 0;
	int          checked = 0;
	int          stb_n = 0;
	logic [7:0]  c_addr;
	logic [7:0]  c_data;
	logic [0:4]  c_func;
	logic [0:6]  c_modx;
	logic        c_init;
	logic [15:0] lreg [8];
	logic [31:0] rd;
	logic        er;

	iocd_decode iocd_decode_i (.sys_clk, .nrst, .paddr, .psel, .penable,
		.pwrite, .pwdata, .prdata, .pready, .pslverr,
		.bidir_channel_bus_in(bus_i), .bidir_channel_par_in(par_i),
		.bidir_channel_bus_out(bus_o), .branch_cond_in(cond),
		.chan_cmd(cmd));
	iocd_attach_model iocd_attach_model_i (.sys_clk, .nrst, .bus_o, .cmd,
		.bus_i, .par_i, .cond, .id_bits, .sense_val, .cond_val);

	always #4 sys_clk = ~sys_clk;

	// Capture what the channel puts on the outbound lane
	always @(posedge sys_clk) begin
		if (cmd.stb === 1'b1) begin
			stb_n++;
			c_addr = bus_o.data[8:15];
			c_func = {bus_o.oe[1], cmd.func};
			c_modx = cmd.modx;
			c_init = cmd.init;
		end
		if (cmd.dstb === 1'b1)
			c_data = bus_o.data[8:15];
	end

	// ------------------------------------------------------------
	// Reporting and bus tasks
	// ------------------------------------------------------------
	task automatic fail(input string m);
		bad_count++;
		$display("BAD %0t %s", $time, m);
	endtask

	task automatic chk_reg(input logic [31:0] g, e, input string m);
		checked++;
		if (g !== e)
			fail(m);
	endtask

	task automatic chk_pin(input logic [15:0] g, e, input string m);
		checked++;
		if (g !== e)
			fail(m);
	endtask

	task automatic close_out;
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// One APB transfer; result left in rd and er
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge sys_clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 64);
		if (n >= 64)
			fail("apb answer missing");
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
		input string m);
		apb(1'b0, a, 32'h0);
		chk_reg(rd, e, m);
	endtask

	// Write address byte and instruction, then poll busy
	task automatic issue(input logic [3:0] dev, op, mod, fn,
		input logic h, input logic [2:0] r, input bit dbl);
		int n;
		n = 0;
		apb(1'b1, OFF_WR0, {24'h0, dev, 4'h0});
		apb(1'b1, OFF_CMD, {16'h0, op, mod, fn, h, r});
		if (dbl) begin
			apb(1'b1, OFF_CMD, {16'h0, op, mod, fn, h, r});
			chk_reg(32'(er), 32'h1, "busy write accepted");
		end
		do begin
			apb(1'b0, OFF_STAT, 32'h0);
			n++;
		end while (rd[STB_BUSY] !== 1'b0 && n < 32);
		if (n >= 32)
			fail("busy stuck");
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	logic [3:0] fns [7] = '{4'h0, 4'h4, 4'h5, 4'h6, 4'h8, 4'hA, 4'hC};
	logic [3:0] bad [8] = '{4'h1, 4'h2, 4'h3, 4'h7, 4'h9, 4'hB, 4'hE, 4'hF};
	logic [3:0] devs [9] = '{4'h2, 4'h4, 4'h5, 4'h8, 4'h9, 4'hA, 4'hB,
		4'hC, 4'hE};

	initial begin
		logic [3:0]  mod, dev, f;
		logic        h;
		logic [2:0]  r;
		logic [7:0]  v, sv, idb;
		logic [11:0] t;
		int          n0;
		void'($urandom(58157));
		repeat (12) @(posedge sys_clk);
		nrst <= 1'b1;
		chk_reg(32'(bus_o), 32'h0, "bus not idle");
		chk_reg(32'(cmd), 32'h0, "cmd not idle");
		rd_chk(OFF_STAT, 32'h0, "stat reset");
		rd_chk(OFF_WR0, 32'h0, "wr0 reset");
		rd_chk(OFF_CHR, 32'h0, "chr reset");
		apb(1'b0, 8'h1C, 32'h0);
		chk_reg(32'(er), 32'h1, "unmapped accepted");
		apb(1'b0, 8'h02, 32'h0);
		chk_reg(32'(er), 32'h1, "misaligned accepted");
		for (int i = 0; i < 8; i++) begin
			lreg[i] = 16'($urandom);
			apb(1'b1, OFF_LOCAL + 8'(4 * i), {16'h0, lreg[i]});
		end
		$display("test reset_and_map done");
		foreach (fns[k]) begin
			f = fns[k];
			mod = 4'($urandom);
			h = 1'($urandom);
			r = 3'($urandom);
			dev = (f == FN_SILS) ? ($urandom % 2 ? 4'h4 : 4'h2)
				: devs[$urandom % 9];
			sv = 8'($urandom);
			idb = 8'($urandom);
			sense_val <= sv;
			id_bits <= idb;
			c_data = 8'hxx;
			n0 = stb_n;
			issue(dev, OP_IMM, mod, f, h, r, f == FN_IOLD);
			chk_pin(16'(stb_n - n0), 16'h1, "stb count");
			chk_pin({dev, mod}, c_addr, "address byte");
			chk_pin({1'b1, f}, c_func, "func or lane");
			chk_pin((f == FN_PLD) ? {r, mod} : {3'b0, mod}, c_modx,
				"modifier");
			if (f inside {FN_IOLD, FN_IOCL, FN_PLD}) begin
				v = h ? lreg[(f == FN_PLD) ? 0 : r][15:8]
					: lreg[(f == FN_PLD) ? 0 : r][7:0];
				chk_pin(c_data, v, "outbound byte");
			end else begin
				v = (f != FN_SILS) ? sv
					: idb & (dev == 4'h4 ? 8'hF2 : 8'h80);
				if (h)
					lreg[r][15:8] = v;
				else
					lreg[r][7:0] = v;
				rd_chk(OFF_LOCAL + 8'(4 * r), {16'h0, lreg[r]},
					"inbound byte");
			end
			rd_chk(OFF_BUF, {24'h0, v}, "buffer byte");
			apb(1'b0, OFF_STAT, 32'h0);
			chk_reg(32'(rd[STB_PERR]), 32'h0, "parity flag");
		end
		$display("test functions done");
		for (int c = 0; c < 2; c++) begin
			t = 12'($urandom);
			cond_val <= 1'(c);
			apb(1'b1, OFF_EXT, {20'h0, t});
			issue(4'hA, OP_IMM, 4'($urandom), FN_BOC, 1'b0, 3'h0, 1'b0);
			chk_reg(32'(rd[STB_TAKEN]), 32'(c), "branch taken");
			rd_chk(OFF_TGT, {20'h0, t}, "branch target");
		end
		$display("test branch done");
		foreach (bad[k]) begin
			n0 = stb_n;
			issue(4'h2, OP_IMM, 4'h3, bad[k], 1'b0, 3'h1, 1'b0);
			chk_reg({rd[STB_NOP], 16'(stb_n - n0)}, 32'h10000,
				"undefined fn");
			apb(1'b1, OFF_STAT, 32'h1 << STB_NOP);
		end
		issue(4'h2, 4'hA, 4'h3, FN_IOLD, 1'b0, 3'h1, 1'b0);
		chk_reg(32'(rd[STB_BADOP]), 32'h1, "bad op code");
		apb(1'b1, OFF_STAT, 32'h1 << STB_BADOP);
		issue(4'h2, OP_IMM, 4'h3, FN_BOC, 1'b0, 3'h1, 1'b0);
		chk_reg(32'(rd[STB_BADOP]), 32'h1, "branch tail");
		$display("test refusals done");
		n0 = stb_n;
		issue(DEV_CHAN, OP_IMM, 4'h5, FN_IOLD, 1'b1, 3'h6, 1'b0);
		chk_pin(16'(stb_n - n0), 16'h0, "channel load drove");
		rd_chk(OFF_CHR, {24'h0, lreg[6][15:8]}, "channel reg");
		issue(DEV_INIT, OP_IMM, 4'h5, FN_IOLD, 1'b0, 3'h2, 1'b0);
		chk_pin(16'(c_init), 16'h1, "init pulse");
		$display("test devices done");
		close_out();
	end

	// Watchdog well beyond the expected run
	initial begin
		#(CLK_NS * 20000);
		fail("timeout");
		close_out();
	end
endmodule
